// file: logic/cmb_pkg.sv
// Shared constants and types of the CAN mode and bit-timing configuration block
package cmb_pkg;
   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [3:0] ADDR_CTL0     = 4'h0;
   localparam logic [3:0] ADDR_CTL1     = 4'h1;
   localparam logic [3:0] ADDR_BTR0     = 4'h2;
   localparam logic [3:0] ADDR_BTR1     = 4'h3;
   localparam logic [3:0] ADDR_INT_STAT = 4'h4;
   localparam logic [3:0] ADDR_INT_EN   = 4'h5;
   localparam logic [3:0] ADDR_INT_CLR  = 4'h6;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int CTL0_INIT_REQ  = 0;
   localparam int CTL0_WAKE_EN   = 2;
   localparam int CTL0_RECOVER   = 6;
   localparam int INT_WAKE       = 0;
   localparam int INT_RX         = 1;
   localparam int INT_TX         = 2;
   localparam int INT_BUSOFF     = 3;
   localparam int INT_W          = 4;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] CTL1_RESET = 8'h00;
   localparam logic [7:0] BTR0_RESET = 8'h00;
   localparam logic [7:0] BTR1_RESET = 8'h00;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS   = 8;
   localparam int WAKE_FILTER_NS  = 2000;
   localparam int WAKE_FILTER_CYC = (WAKE_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int QUANTA_W        = 5;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic module_enable_bit;
      logic clock_source_select;
      logic internal_loopback_bit;
      logic listen_only_bit;
      logic busoff_recovery_select;
      logic wake_filter_select;
      logic [1:0] unused;
   } cmb_ctl_s;

   typedef struct packed {
      logic       sample_count_select;
      logic [2:0] time_segment_two;
      logic [3:0] time_segment_one;
   } cmb_btr_s;

   typedef enum logic [1:0] {
      ST_RUN  = 2'b01,
      ST_INIT = 2'b10
   } cmb_mode_e;
endpackage

// file: logic/cmb_bit_timer.sv
// Prescaler and time-quantum sequencer of one bit time
module cmb_bit_timer #(
   parameter int PW = 6,
   parameter int S1W = 4,
   parameter int S2W = 3
) (
   input  wire logic           sys_clk,
   input  wire logic           resetn,
   input  wire logic           run,
   input  wire logic           tick,
   input  wire logic [PW-1:0]  prescale,
   input  wire logic [S1W-1:0] seg1,
   input  wire logic [S2W-1:0] seg2,
   output logic                quantum_tick,
   output logic                early_tick,
   output logic                sample_tick,
   output logic                bit_end
);
   localparam int QW = cmb_pkg::QUANTA_W;
   logic [PW-1:0] pcnt;
   logic [QW-1:0] qcnt;
   logic [QW-1:0] s1;
   logic [QW-1:0] q_last;

   assign s1           = QW'(seg1);
   assign q_last       = QW'(s1 + QW'(seg2) + QW'(2));
   assign quantum_tick = run && tick && (pcnt == prescale);
   // Two quanta ending just before the sample point feed the triple vote
   assign early_tick   = quantum_tick && (qcnt == s1 || qcnt == QW'(s1 - QW'(1)));
   assign sample_tick  = quantum_tick && (qcnt == QW'(s1 + QW'(1)));
   assign bit_end      = quantum_tick && (qcnt == q_last);

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         pcnt <= '0;
      end else if (!run) begin
         pcnt <= '0;
      end else if (tick) begin
         pcnt <= (pcnt == prescale) ? '0 : PW'(pcnt + PW'(1));
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         qcnt <= '0;
      end else if (!run) begin
         qcnt <= '0;
      end else if (quantum_tick) begin
         qcnt <= (qcnt == q_last) ? '0 : QW'(qcnt + QW'(1));
      end
   end
endmodule // cmb_bit_timer

// file: logic/cmb_sampler.sv
// Single or triple sample bit decision at the sample point
module cmb_sampler (
   input  wire logic sys_clk,
   input  wire logic resetn,
   input  wire logic bit_in,
   input  wire logic triple,
   input  wire logic early_tick,
   input  wire logic sample_tick,
   output logic      bit_out,
   output logic      bit_valid
);
   logic e0;
   logic e1;

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         e0 <= 1'b1;
         e1 <= 1'b1;
      end else if (early_tick) begin
         e0 <= bit_in;
         e1 <= e0;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         bit_out   <= 1'b1;
         bit_valid <= 1'b0;
      end else begin
         bit_valid <= sample_tick;
         if (sample_tick) begin
            bit_out <= triple ? ((e0 & e1) | (e0 & bit_in) | (e1 & bit_in)) : bit_in;
         end
      end
   end

   single_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      sample_tick && !triple |=> bit_out == $past(bit_in))
      else $error("single sample not taken at sample point");
endmodule // cmb_sampler

// file: logic/cmb_config.sv
// CAN mode control, bit-timing configuration, pin steering and interrupts
//
// Notes on behaviour
// - Control register 1 and bit-timing writes land only while init request and init acknowledge are both one.
// - Module enable takes one write in normal system mode and any number in special mode, in init.
// - Clock source select zero runs the bit timing from the oscillator, one from the bus clock.
// - Loopback feeds the transmit stream to the receiver, ignores the receive pin, holds TX at 1.
// - Loopback ignores the acknowledge slot and raises both transmit and receive interrupts.
// - Listen-only receives valid frames but sends no acknowledge or error frames, counters frozen.
// - Listen-only mode never transmits.
// - Bus-off recovery select zero recovers automatically, one only on a software request.
// - Wake filter select zero wakes on any dominant level, one only on a long enough dominant pulse.
// - The six-bit prescaler field gives a prescaler of field plus one, from 1 to 64.
// - The bit-timing register holds sampling and both segments and is writable only in init.
// - Sampling zero takes one sample at the sample point, one takes three and a majority vote.
// - Segment 2 sits in bits 6 to 4 and segment 1 in bits 3 to 0 and set bit length and sample point.
//
// The strobed register port is this design's own decision.
module cmb_config (
   input  wire logic       sys_clk,
   input  wire logic       resetn,
   input  wire logic [3:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic [7:0]      reg_rdata,
   input  wire logic       special_mode,
   input  wire logic       osc_clk_pin,
   input  wire logic       bus_receive_pin,
   output logic            bus_transmit_pin,
   input  wire logic       tx_bit,
   input  wire logic       tx_done,
   input  wire logic       rx_done,
   input  wire logic       busoff_state,
   input  wire logic       recess_seq_done,
   input  wire logic       sleep_active,
   output logic            init_mode,
   output logic            module_enabled,
   output logic            tx_allowed,
   output logic            ack_ignore,
   output logic            ack_suppress,
   output logic            error_frame_suppress,
   output logic            error_count_freeze,
   output logic            busoff_recover,
   output logic            wake_up,
   output logic            quantum_tick,
   output logic            bit_end,
   output logic            rx_bit,
   output logic            rx_bit_valid,
   output logic            irq
);
   localparam int WCW = $clog2(cmb_pkg::WAKE_FILTER_CYC + 1);
   localparam logic [WCW-1:0] WAKE_CYC = WCW'(cmb_pkg::WAKE_FILTER_CYC);

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic rx_meta;
   logic rx_sync;
   logic osc_meta;
   logic osc_sync;
   logic osc_prev;

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         rx_meta  <= 1'b1;
         rx_sync  <= 1'b1;
         osc_meta <= 1'b0;
         osc_sync <= 1'b0;
         osc_prev <= 1'b0;
      end else begin
         rx_meta  <= bus_receive_pin;
         rx_sync  <= rx_meta;
         osc_meta <= osc_clk_pin;
         osc_sync <= osc_meta;
         osc_prev <= osc_sync;
      end
   end

   // ----------------------------------------------------------------
   // Init handshake and register file
   // ----------------------------------------------------------------
   cmb_pkg::cmb_mode_e mode;
   cmb_pkg::cmb_ctl_s  ctl;
   cmb_pkg::cmb_btr_s  btr;
   logic [7:0]         btr0;
   logic               init_req;
   logic               init_ack;
   logic               wake_en;
   logic               recover_req;
   logic               enable_locked;
   logic               cfg_open;
   logic               wr_ctl1;
   logic               wr_btr;
   logic [cmb_pkg::INT_W-1:0] int_stat;
   logic [cmb_pkg::INT_W-1:0] int_en;
   logic [cmb_pkg::INT_W-1:0] int_set;
   logic [cmb_pkg::INT_W-1:0] int_clr;

   assign init_ack = (mode == cmb_pkg::ST_INIT);
   assign cfg_open = init_req && init_ack;
   assign wr_ctl1  = reg_wr && reg_addr == cmb_pkg::ADDR_CTL1 && cfg_open;
   assign wr_btr   = reg_wr && (reg_addr == cmb_pkg::ADDR_BTR0 ||
                                reg_addr == cmb_pkg::ADDR_BTR1) && cfg_open;
   assign init_mode = init_ack;

   // Acknowledge trails the request by one cycle so software sees a real handshake
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         mode <= cmb_pkg::ST_INIT;
      end else begin
         case (mode)
            cmb_pkg::ST_RUN:  if (init_req) mode <= cmb_pkg::ST_INIT;
            cmb_pkg::ST_INIT: if (!init_req) mode <= cmb_pkg::ST_RUN;
            default:          mode <= cmb_pkg::ST_INIT;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         init_req    <= 1'b1;
         wake_en     <= 1'b0;
         recover_req <= 1'b0;
      end else begin
         recover_req <= 1'b0;
         if (reg_wr && reg_addr == cmb_pkg::ADDR_CTL0) begin
            init_req    <= reg_wdata[cmb_pkg::CTL0_INIT_REQ];
            wake_en     <= reg_wdata[cmb_pkg::CTL0_WAKE_EN];
            recover_req <= reg_wdata[cmb_pkg::CTL0_RECOVER];
         end
      end
   end

   // Enable locks after its first write unless the chip is in special mode
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         ctl           <= cmb_pkg::CTL1_RESET;
         enable_locked <= 1'b0;
      end else if (wr_ctl1) begin
         ctl.clock_source_select    <= reg_wdata[6];
         ctl.internal_loopback_bit  <= reg_wdata[5];
         ctl.listen_only_bit        <= reg_wdata[4];
         ctl.busoff_recovery_select <= reg_wdata[3];
         ctl.wake_filter_select     <= reg_wdata[2];
         if (special_mode || !enable_locked) begin
            ctl.module_enable_bit <= reg_wdata[7];
            enable_locked         <= !special_mode;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         btr0 <= cmb_pkg::BTR0_RESET;
         btr  <= cmb_pkg::BTR1_RESET;
      end else if (wr_btr) begin
         if (reg_addr == cmb_pkg::ADDR_BTR0) begin
            btr0 <= reg_wdata;
         end else begin
            btr <= reg_wdata;
         end
      end
   end

   // ----------------------------------------------------------------
   // Interrupt status
   // ----------------------------------------------------------------
   logic wake_hit;

   // Loopback reports the own frame as received as well
   assign int_set[cmb_pkg::INT_WAKE]   = wake_hit;
   assign int_set[cmb_pkg::INT_RX]     = rx_done || (tx_done && ctl.internal_loopback_bit);
   assign int_set[cmb_pkg::INT_TX]     = tx_done;
   assign int_set[cmb_pkg::INT_BUSOFF] = busoff_state;
   assign int_clr = (reg_wr && reg_addr == cmb_pkg::ADDR_INT_CLR) ?
                    reg_wdata[cmb_pkg::INT_W-1:0] : '0;

   // Set wins over a clear in the same cycle
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         int_stat <= '0;
      end else begin
         int_stat <= (int_stat & ~int_clr) | int_set;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         int_en <= '0;
      end else if (reg_wr && reg_addr == cmb_pkg::ADDR_INT_EN) begin
         int_en <= reg_wdata[cmb_pkg::INT_W-1:0];
      end
   end

   assign irq = |(int_stat & int_en);

   // ----------------------------------------------------------------
   // Read port
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            cmb_pkg::ADDR_CTL0:     reg_rdata <= {5'h00, wake_en, 1'b0, init_req};
            cmb_pkg::ADDR_CTL1:     reg_rdata <= {ctl[7:2], 1'b0, init_ack};
            cmb_pkg::ADDR_BTR0:     reg_rdata <= btr0;
            cmb_pkg::ADDR_BTR1:     reg_rdata <= btr;
            cmb_pkg::ADDR_INT_STAT: reg_rdata <= {4'h0, int_stat};
            cmb_pkg::ADDR_INT_EN:   reg_rdata <= {4'h0, int_en};
            default:                reg_rdata <= 8'h00;
         endcase
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   // ----------------------------------------------------------------
   // Mode steering
   // ----------------------------------------------------------------
   logic rx_mux;
   logic run;
   logic tick;

   assign module_enabled       = ctl.module_enable_bit;
   assign ack_ignore           = ctl.internal_loopback_bit;
   assign ack_suppress         = ctl.listen_only_bit;
   assign error_frame_suppress = ctl.listen_only_bit;
   assign error_count_freeze   = ctl.listen_only_bit;
   assign tx_allowed           = ctl.module_enable_bit && !init_ack && !ctl.listen_only_bit;
   assign rx_mux = ctl.internal_loopback_bit ? tx_bit : rx_sync;
   assign run    = ctl.module_enable_bit && !init_ack;
   assign tick   = ctl.clock_source_select ? 1'b1 : (osc_sync && !osc_prev);

   // Loopback and listen-only both keep the line recessive
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         bus_transmit_pin <= 1'b1;
      end else begin
         bus_transmit_pin <= (ctl.internal_loopback_bit || ctl.listen_only_bit || !run)
                             ? 1'b1 : tx_bit;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         busoff_recover <= 1'b0;
      end else begin
         busoff_recover <= busoff_state &&
                           (ctl.busoff_recovery_select ? recover_req : recess_seq_done);
      end
   end

   // ----------------------------------------------------------------
   // Wake-up detection
   // ----------------------------------------------------------------
   // The filter counts bus-clock cycles, so a glitch shorter than the window never wakes
   logic [WCW-1:0] dom_cnt;
   logic           wake_arm;

   assign wake_arm = sleep_active && wake_en && !rx_sync;
   assign wake_hit = wake_arm && (!ctl.wake_filter_select || dom_cnt == WAKE_CYC);
   assign wake_up  = wake_hit;

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         dom_cnt <= '0;
      end else if (!wake_arm) begin
         dom_cnt <= '0;
      end else if (dom_cnt != WAKE_CYC) begin
         dom_cnt <= WCW'(dom_cnt + WCW'(1));
      end
   end

   // ----------------------------------------------------------------
   // Bit timing
   // ----------------------------------------------------------------
   logic early_tick;
   logic sample_tick;

   cmb_bit_timer #(.PW(6), .S1W(4), .S2W(3)) u_timer (
      .sys_clk      (sys_clk),
      .resetn       (resetn),
      .run          (run),
      .tick         (tick),
      .prescale     (btr0[5:0]),
      .seg1         (btr.time_segment_one),
      .seg2         (btr.time_segment_two),
      .quantum_tick (quantum_tick),
      .early_tick   (early_tick),
      .sample_tick  (sample_tick),
      .bit_end      (bit_end)
   );

   // Triple sampling relies on software keeping the pre-sample segment at two quanta or more
   cmb_sampler u_sampler (
      .sys_clk     (sys_clk),
      .resetn      (resetn),
      .bit_in      (rx_mux),
      .triple      (btr.sample_count_select),
      .early_tick  (early_tick),
      .sample_tick (sample_tick),
      .bit_out     (rx_bit),
      .bit_valid   (rx_bit_valid)
   );

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);

   logic [7:0] tick_gap;
   logic       gap_ok;

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         tick_gap <= 8'h00;
         gap_ok   <= 1'b0;
      end else if (!run || !ctl.clock_source_select || wr_btr) begin
         tick_gap <= 8'h00;
         gap_ok   <= 1'b0;
      end else if (quantum_tick) begin
         tick_gap <= 8'h00;
         gap_ok   <= 1'b1;
      end else begin
         tick_gap <= 8'(tick_gap + 8'h01);
      end
   end

   sequence s_loop_tx;
      tx_done && ctl.internal_loopback_bit;
   endsequence

   sequence s_both_flags;
      int_stat[cmb_pkg::INT_RX] && int_stat[cmb_pkg::INT_TX];
   endsequence

   ctl_gate_a: assert property (reg_wr && reg_addr == cmb_pkg::ADDR_CTL1 && !cfg_open
      |=> $stable(ctl))
      else $error("control register changed outside init");
   btr_gate_a: assert property (reg_wr && reg_addr == cmb_pkg::ADDR_BTR1 && !cfg_open
      |=> $stable(btr))
      else $error("bit timing changed outside init");
   enable_once_a: assert property (enable_locked && !special_mode
      |=> $stable(ctl.module_enable_bit))
      else $error("module enable rewritten after lock");
   clock_src_a: assert property (!ctl.clock_source_select |-> tick == (osc_sync && !osc_prev))
      else $error("oscillator tick not selected");
   loop_pin_a: assert property (ctl.internal_loopback_bit [*2] |-> bus_transmit_pin)
      else $error("transmit pin not recessive in loopback");
   loop_rx_a: assert property (ctl.internal_loopback_bit |-> rx_mux == tx_bit)
      else $error("receiver not fed from transmitter in loopback");
   loop_irq_a: assert property (s_loop_tx |=> s_both_flags)
      else $error("loopback did not raise both interrupts");
   listen_out_a: assert property (ctl.listen_only_bit |-> ack_suppress && error_frame_suppress
      && error_count_freeze && !tx_allowed)
      else $error("listen-only outputs wrong");
   listen_pin_a: assert property (ctl.listen_only_bit [*2] |-> bus_transmit_pin)
      else $error("transmit pin driven in listen-only");
   busoff_user_a: assert property (busoff_state && ctl.busoff_recovery_select && !recover_req
      |=> !busoff_recover)
      else $error("recovery without software request");
   wake_fast_a: assert property (wake_arm && !ctl.wake_filter_select |-> wake_up)
      else $error("unfiltered wake missed");
   wake_filt_a: assert property (ctl.wake_filter_select && wake_up |-> dom_cnt == WAKE_CYC)
      else $error("filtered wake came too early");
   prescale_a: assert property (gap_ok && quantum_tick && $stable(btr0)
      |-> tick_gap == {2'b00, btr0[5:0]})
      else $error("quantum length differs from prescaler");
   irq_line_a: assert property (irq == |(int_stat & int_en))
      else $error("interrupt line mismatch");
endmodule // cmb_config

// file: test/cmb_bus_node.sv
// Far-side node model: drives the bus line dominant on command
module cmb_bus_node (
   input  wire logic sys_clk,
   input  wire logic dominant,
   output logic      bus_line
);
   timeunit 1ns;
   timeprecision 1ps;
   // Released bus is driven recessive on the next clock edge, never left at the last value
   always @(posedge sys_clk) begin
      bus_line <= !dominant;
   end
endmodule // cmb_bus_node

// file: test/tb.sv
// Self-checking bench of the CAN mode and bit-timing configuration block
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic       sys_clk = 0, resetn = 0, reg_wr = 0, reg_rd = 0, special_mode = 0, prev;
   logic       tx_bit = 0, tx_done = 0, rx_done = 0, busoff_state = 0, sleep_active = 0;
   logic       dom = 0, bus_receive_pin, bus_transmit_pin, init_mode, tx_allowed, ack_ignore;
   logic       ack_suppress, error_frame_suppress, error_count_freeze, wake_up, irq;
   logic       quantum_tick, bit_end, rx_bit, rx_bit_valid, module_enabled, busoff_recover;
   logic       osc = 0, seq = 0;
   logic [3:0] reg_addr = 0;
   logic [7:0] reg_wdata = 0, reg_rdata, m_ctl = 0, m_btr = 0;
   logic [7:0] md [3] = '{8'h00, 8'h10, 8'h20};
   int         err_total = 0, num_checks = 0, cyc = 0, p, s1, s2;
   bit         m_init = 1, lock = 0;

   cmb_bus_node cmb_bus_node_inst (.sys_clk, .dominant(dom), .bus_line(bus_receive_pin));
   cmb_config cmb_config_inst (.sys_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .special_mode, .osc_clk_pin(osc), .bus_receive_pin, .bus_transmit_pin,
      .tx_bit, .tx_done, .rx_done, .busoff_state, .recess_seq_done(seq), .sleep_active,
      .init_mode, .module_enabled, .tx_allowed, .ack_ignore, .ack_suppress,
      .error_frame_suppress, .error_count_freeze, .busoff_recover, .wake_up, .quantum_tick,
      .bit_end, .rx_bit, .rx_bit_valid, .irq);

   initial begin
      forever #4 sys_clk = ~sys_clk;
   end

   // Oscillator pin at half the system clock rate: one rising edge every two cycles
   always @(posedge sys_clk) osc <= ~osc;

   // Cut a hang short well past the expected run length
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         end_of_test();
      end
   end

   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      num_checks++;
      if (g !== e) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask

   // Model update runs after the write edge so mode inputs have settled
   task automatic wrm(input logic [3:0] a, input logic [7:0] d);
      wr(a, d);
      if (a == 4'h3 && m_init) m_btr = d;
      if (a == 4'h1 && m_init) begin
         m_ctl[6:2] = d[6:2];
         if (special_mode || !lock) m_ctl[7] = d[7];
         if (!special_mode) lock = 1;
      end
      if (a == 4'h0) m_init = d[0];
   endtask

   task automatic rdc(input logic [3:0] a, input logic [7:0] e);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 chk($sformatf("reg %h", a), e, reg_rdata);
   endtask

   task automatic per(input bit b, input int e);
      int n;
      // Start on a falling edge so the first pulse is not counted twice in its own cycle
      @(negedge sys_clk);
      for (n = 0; n < 3000 && (b ? bit_end : quantum_tick) !== 1'b1; n++) @(negedge sys_clk);
      n = 0;
      do begin
         @(negedge sys_clk);
         n++;
      end while ((b ? bit_end : quantum_tick) !== 1'b1 && n < 3000);
      chk(b ? "bit period" : "quantum period", 8'(e), 8'(n));
   endtask

   task end_of_test;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Test sequence
   // ----------------------------------------------------------------
   initial begin
      void'($urandom(32'h27c09b34));
      repeat (16) @(posedge sys_clk);
      resetn <= 1'b1;
      rdc(4'h1, 8'h01);
      rdc(4'h3, 8'h00);
      rdc(4'h9, 8'h00);
      p = $urandom % 4;
      s1 = 1 + $urandom % 4;
      s2 = $urandom % 4;
      wrm(4'h2, 8'(p));
      wrm(4'h3, {1'b0, 3'(s2), 4'(s1)});
      rdc(4'h3, m_btr);
      special_mode <= 1'b1;
      wrm(4'h1, 8'h80);
      wrm(4'h1, 8'h40);
      rdc(4'h1, {m_ctl[7:2], 2'b01});
      special_mode <= 1'b0;
      wrm(4'h1, 8'hc0);
      wrm(4'h1, 8'h40);
      rdc(4'h1, {m_ctl[7:2], 2'b01});
      wrm(4'h0, 8'h00);
      repeat (2) @(posedge sys_clk);
      wrm(4'h3, ~m_btr);
      wrm(4'h1, 8'h00);
      rdc(4'h3, m_btr);
      rdc(4'h1, {m_ctl[7:2], 2'b00});
      chk("init mode", 8'h00, {7'd0, init_mode});
      $display("done: registers");
      per(0, p + 1);
      per(1, (s1 + s2 + 3) * (p + 1));
      wrm(4'h0, 8'h01);
      wrm(4'h1, 8'h80);
      wrm(4'h0, 8'h00);
      per(0, 2 * (p + 1));
      $display("done: bit timing");
      for (int i = 0; i < 3; i++) begin
         wrm(4'h0, 8'h01);
         wrm(4'h3, {i == 2, m_btr[6:0]});
         wrm(4'h1, 8'hc0 | md[i]);
         wrm(4'h0, 8'h00);
         repeat (3) @(posedge sys_clk);
         repeat (8) begin
            @(posedge sys_clk);
            prev = tx_bit;
            tx_bit <= 1'($urandom);
            @(negedge sys_clk);
            chk("tx pin", {7'd0, md[i] != 0 || prev}, {7'd0, bus_transmit_pin});
         end
         // Receive line stays recessive, so a dominant decision can only come from the loop
         @(posedge sys_clk) tx_bit <= 1'b0;
         repeat (2) @(posedge rx_bit_valid);
         @(negedge sys_clk);
         chk("rx bit", {7'd0, md[i] != 8'h20}, {7'd0, rx_bit});
         chk("mode outs", {2'd0, 1'b1, md[i] != 8'h10, md[i] == 8'h20, {3{md[i] == 8'h10}}},
             {2'd0, module_enabled, tx_allowed, ack_ignore, ack_suppress, error_frame_suppress,
              error_count_freeze});
      end
      wr(4'h5, 8'h0f);
      @(posedge sys_clk) tx_done <= 1'b1;
      @(posedge sys_clk) tx_done <= 1'b0;
      rdc(4'h4, 8'h06);
      chk("irq", 8'h01, {7'd0, irq});
      wr(4'h6, 8'h06);
      wr(4'h5, 8'h00);
      @(posedge sys_clk) {rx_done, busoff_state, seq} <= 3'b111;
      @(posedge sys_clk) {rx_done, busoff_state, seq} <= 3'b000;
      @(negedge sys_clk) chk("recover", 8'h01, {7'd0, busoff_recover});
      rdc(4'h4, 8'h0a);
      chk("irq", 8'h00, {7'd0, irq});
      wr(4'h6, 8'h0f);
      wr(4'h0, 8'h04);
      sleep_active <= 1'b1;
      dom <= 1'b1;
      repeat (6) @(posedge sys_clk);
      @(negedge sys_clk);
      chk("wake", 8'h01, {7'd0, wake_up});
      rdc(4'h4, 8'h01);
      dom <= 1'b0;
      wrm(4'h0, 8'h05);
      wrm(4'h1, 8'hc4);
      wrm(4'h0, 8'h04);
      dom <= 1'b1;
      // Two synchroniser stages and the node's register add three cycles to the filter
      repeat (cmb_pkg::WAKE_FILTER_CYC - 10) @(posedge sys_clk);
      @(negedge sys_clk) chk("filtered wake", 8'h00, {7'd0, wake_up});
      repeat (20) @(posedge sys_clk);
      @(negedge sys_clk) chk("filtered wake", 8'h01, {7'd0, wake_up});
      $display("done: modes and interrupts");
      end_of_test();
   end
endmodule // tb
